// ---- rtl/ditd_pkg.sv ----
package ditd_pkg;
  localparam int          NUM_TERM    = 5;
  localparam int          NUM_SPEED   = 16;
  localparam int          FREQ_W      = 16;
  localparam int          FUNC_W      = 5;
  localparam int          SPD_W       = 4;

  // input function codes
  localparam logic [4:0]  FN_FWD      = 5'h00;
  localparam logic [4:0]  FN_REV      = 5'h01;
  localparam logic [4:0]  FN_SEL0     = 5'h02;
  localparam logic [4:0]  FN_SEL1     = 5'h03;
  localparam logic [4:0]  FN_SEL2     = 5'h04;
  localparam logic [4:0]  FN_SEL3     = 5'h05;
  localparam logic [4:0]  FN_NONE     = 5'h1f;

  // register byte addresses (word index * 4)
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_TERM0  = 8'h08;
  localparam logic [7:0]  ADDR_TGT    = 8'h1c;
  localparam logic [7:0]  ADDR_SPD0   = 8'h40;
  localparam logic [7:0]  ADDR_BAD    = 8'h80;

  // control register fields
  localparam int          CTRL_SRC    = 0;
  localparam int          CTRL_KEYREV = 1;
  localparam int          CTRL_KEYRUN = 2;
  // term register fields
  localparam int          TERM_NC     = 8;
  // status fields
  localparam int          ST_RUN      = 0;
  localparam int          ST_REV      = 1;
  localparam int          ST_CONF     = 2;
  localparam int          ST_IDX      = 4;
  localparam int          ST_PIN      = 8;

  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam logic [31:0] DEAD_WORD   = 32'hdead_beef;

  typedef enum logic [1:0] {
    DITD_STOP,
    DITD_FWD,
    DITD_REV
  } ditd_dir_e;

  typedef struct packed {
    logic       run;
    logic       rev;
    logic [3:0] idx;
  } ditd_cmd_s;

  typedef struct packed {
    logic [4:0] func;
    logic       nc;
  } ditd_term_s;
endpackage

// ---- rtl/ditd_speed_mem.sv ----
module ditd_speed_mem
  import ditd_pkg::*;
#(
  parameter int DEPTH = NUM_SPEED,
  parameter int WIDTH = FREQ_W
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// ---- rtl/ditd_top.sv ----
// Notes on behaviour
// RULE1 - forward input high runs forward, low stops
// RULE2 - reverse input high runs reverse, low stops
// RULE3 - forward and reverse together means stop
// RULE4 - normally closed terminal asserts when unpowered
// RULE5 - five terminals, each with function assignment
// RULE6 - key direction setting never affects terminals
// RULE7 - run is level sensitive, active at power-up
// RULE8 - sixteen stored frequencies, four-bit binary select
// RULE9 - decoding follows assignment, not terminal position
// RULE10 - select bit0 is lsb, codes 02 to 05
// RULE11 - user allocates select bits from lsb upward
// RULE12 - index zero uses base frequency setting
// RULE13 - target updates at once on select change
// RULE14 - terminal run only when source is terminals
// RULE15 - unassigned select bits read as zero
// RULE16 - terminals pass three synchroniser flip-flops
module ditd_top
  import ditd_pkg::*;
#(
  parameter int NTERM = NUM_TERM,
  parameter int FW    = FREQ_W
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [NTERM-1:0] term_pin,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  output logic                  avs_readdatavalid_q,
  output logic                  run_cmd_q,
  output logic                  rev_cmd_q,
  output logic      [3:0]       speed_idx_q,
  output logic      [FW-1:0]    target_freq_q
);
  logic [NTERM-1:0] s1_q, s2_q, s3_q, lvl_q;
  ditd_term_s       term_q [NTERM];
  logic [31:0]      ctrl_q;
  logic [FW-1:0]    base_freq_q;
  logic             wait_q;
  ditd_cmd_s        cmd_d;
  logic [NTERM-1:0] act;
  logic             fwd_act, rev_act;
  logic [3:0]       sel;
  logic [FW-1:0]    mem_rdata;
  logic             mem_we;
  logic [3:0]       idx_pipe_q;
  logic             acc;
  logic [31:0]      rd_d;
  ditd_dir_e        dir;

  // three-stage synchroniser; level accepted when stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= term_pin; // RULE16
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NTERM; g++) begin : g_term
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          lvl_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          lvl_q[g] <= s3_q[g]; // RULE16
        end
      end
      assign act[g] = lvl_q[g] ^ term_q[g].nc; // RULE4
      chk_sel_bit0: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        act[g] && term_q[g].func == FN_SEL0 |-> sel[0])
        else $error("select bit 0 not decoded");
      chk_sel_bit3: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        act[g] && term_q[g].func == FN_SEL3 |-> sel[3])
        else $error("select bit 3 not decoded");
    end
  endgenerate

  // function decode by assignment only
  always_comb begin
    fwd_act = 1'b0;
    rev_act = 1'b0;
    sel     = 4'h0; // RULE15
    for (int i = 0; i < NTERM; i++) begin
      if (act[i]) begin
        case (term_q[i].func) // RULE9
          FN_FWD:  fwd_act = 1'b1; // RULE1
          FN_REV:  rev_act = 1'b1; // RULE2
          FN_SEL0: sel[0]  = 1'b1; // RULE10
          FN_SEL1: sel[1]  = 1'b1;
          FN_SEL2: sel[2]  = 1'b1;
          FN_SEL3: sel[3]  = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    dir = DITD_STOP;
    if (ctrl_q[CTRL_SRC]) begin // RULE14
      if (fwd_act && !rev_act) begin
        dir = DITD_FWD; // RULE1
      end else if (rev_act && !fwd_act) begin
        dir = DITD_REV; // RULE2
      end
    end else if (ctrl_q[CTRL_KEYRUN]) begin
      dir = ctrl_q[CTRL_KEYREV] ? DITD_REV : DITD_FWD; // RULE6
    end
    case (dir)
      DITD_FWD: begin
        cmd_d.run = 1'b1;
        cmd_d.rev = 1'b0;
      end
      DITD_REV: begin
        cmd_d.run = 1'b1;
        cmd_d.rev = 1'b1;
      end
      default: begin
        cmd_d.run = 1'b0; // RULE3
        cmd_d.rev = 1'b0;
      end
    endcase
    cmd_d.idx = sel;
  end

  // level-driven: no edge needed after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_cmd_q   <= 1'b0;
      rev_cmd_q   <= 1'b0;
      speed_idx_q <= 4'h0;
    end else begin
      run_cmd_q   <= cmd_d.run; // RULE7
      rev_cmd_q   <= cmd_d.rev;
      speed_idx_q <= cmd_d.idx; // RULE13
    end
  end

  assign mem_we = avs_write && !wait_q && avs_address >= ADDR_SPD0 && avs_address < ADDR_BAD;

  ditd_speed_mem #(
    .DEPTH (NUM_SPEED),
    .WIDTH (FW)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (avs_address[5:2]),
    .wdata (avs_writedata[FW-1:0]),
    .raddr (speed_idx_q),
    .rdata (mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_pipe_q <= 4'h0;
    end else begin
      idx_pipe_q <= speed_idx_q;
    end
  end

  // entry zero comes from the base frequency setting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_freq_q <= '0;
    end else if (idx_pipe_q == 4'h0) begin
      target_freq_q <= base_freq_q; // RULE12
    end else begin
      target_freq_q <= mem_rdata; // RULE8
    end
  end

  // bus: one wait cycle for each access, then answer
  assign acc = avs_read || avs_write;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(acc && wait_q);
    end
  end

  // waitrequest idles high so the pin comes straight from the wait flop
  always_comb begin
    avs_waitrequest = wait_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q      <= CTRL_RST;
      base_freq_q <= '0;
    end else if (avs_write && !wait_q) begin
      if (avs_address == ADDR_CTRL && avs_byteenable[0]) begin
        ctrl_q <= {29'h0, avs_writedata[2:0]}; // RULE6
      end
      if (avs_address == ADDR_SPD0) begin
        base_freq_q <= avs_writedata[FW-1:0]; // RULE12
      end
    end
  end

  generate
    for (g = 0; g < NTERM; g++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          term_q[g].func <= (g < 2) ? 5'(g) : FN_NONE;
          term_q[g].nc   <= 1'b0;
        end else if (avs_write && !wait_q && avs_address == ADDR_TERM0 + 8'(4 * g)) begin
          term_q[g].func <= avs_writedata[FUNC_W-1:0]; // RULE5
          term_q[g].nc   <= avs_writedata[TERM_NC];
        end
      end
      chk_term_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        avs_write && !avs_waitrequest && avs_address == ADDR_TERM0 + 8'(4 * g) |=> term_q[g].func == $past(avs_writedata[FUNC_W-1:0]))
        else $error("terminal assignment not written");
    end
  endgenerate

  always_comb begin
    rd_d = DEAD_WORD;
    if (avs_address == ADDR_CTRL) begin
      rd_d = ctrl_q;
    end else if (avs_address == ADDR_STATUS) begin
      rd_d = {19'h0, lvl_q, speed_idx_q, 1'b0, fwd_act & rev_act, rev_cmd_q, run_cmd_q};
    end else if (avs_address == ADDR_TGT) begin
      rd_d = {16'h0, target_freq_q};
    end else if (avs_address == ADDR_SPD0) begin
      rd_d = {16'h0, base_freq_q};
    end else begin
      for (int i = 0; i < NTERM; i++) begin
        if (avs_address == ADDR_TERM0 + 8'(4 * i)) begin
          rd_d = {23'h0, term_q[i].nc, 3'h0, term_q[i].func};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata        <= '0;
      avs_readdatavalid_q <= 1'b0;
    end else begin
      avs_readdata        <= rd_d;
      avs_readdatavalid_q <= avs_read && wait_q;
    end
  end

  chk_conflict_stop: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    ctrl_q[CTRL_SRC] && fwd_act && rev_act |=> !run_cmd_q)
    else $error("both directions did not stop");
  chk_fwd_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    ctrl_q[CTRL_SRC] && fwd_act && !rev_act |=> run_cmd_q && !rev_cmd_q)
    else $error("forward not run");
  chk_rev_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    ctrl_q[CTRL_SRC] && rev_act && !fwd_act |=> run_cmd_q && rev_cmd_q)
    else $error("reverse not run");
  chk_src_gate: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    !ctrl_q[CTRL_SRC] && !ctrl_q[CTRL_KEYRUN] |=> !run_cmd_q)
    else $error("run without source");
  chk_idx_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    1'b1 |=> speed_idx_q == $past(sel))
    else $error("index lag");
  chk_base_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    idx_pipe_q == 4'h0 |=> target_freq_q == $past(base_freq_q))
    else $error("speed zero not base");
  chk_sync_hold: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    s2_q != s3_q |=> lvl_q == $past(lvl_q))
    else $error("level taken before agree");
  chk_nc_polarity: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    ctrl_q[CTRL_SRC] && term_q[0].func == FN_FWD && term_q[0].nc && !lvl_q[0] && !rev_act |=> run_cmd_q && !rev_cmd_q)
    else $error("nc forward input did not run");
  chk_wait_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !acc |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  chk_wait_one: assert property (@(posedge clk) disable iff (sys_rst)
    acc && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  chk_wait_rearm: assert property (@(posedge clk) disable iff (sys_rst)
    acc && !avs_waitrequest |=> avs_waitrequest)
    else $error("next access not held off");
  chk_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && avs_waitrequest |=> avs_readdatavalid_q)
    else $error("read valid missing");
  chk_valid_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_read |=> !avs_readdatavalid_q)
    else $error("read valid without read");
  chk_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    avs_write && !avs_waitrequest && avs_address == ADDR_CTRL && avs_byteenable[0]
      |=> ctrl_q[CTRL_KEYRUN:CTRL_SRC] == $past(avs_writedata[CTRL_KEYRUN:CTRL_SRC]))
    else $error("control write lost");
  chk_ctrl_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    avs_read && avs_address == ADDR_CTRL |=> avs_readdata == $past(ctrl_q))
    else $error("control read wrong");
  chk_bad_read: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && avs_address == ADDR_BAD |=> avs_readdata == DEAD_WORD)
    else $error("unmapped read wrong");
  chk_status_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    avs_read && avs_address == ADDR_STATUS
      |=> avs_readdata[ST_CONF] == ($past(fwd_act) && $past(rev_act)) && avs_readdata[ST_RUN] == $past(run_cmd_q))
    else $error("status run or conflict wrong");
  chk_status_idx: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    avs_read && avs_address == ADDR_STATUS |=> avs_readdata[ST_IDX +: SPD_W] == $past(speed_idx_q))
    else $error("status index wrong");
  chk_tgt_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    avs_read && avs_address == ADDR_TGT |=> avs_readdata[FW-1:0] == $past(target_freq_q))
    else $error("target read wrong");
  chk_spd0_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    avs_read && avs_address == ADDR_SPD0 |=> avs_readdata[FW-1:0] == $past(base_freq_q))
    else $error("base read wrong");
  chk_term_read: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    avs_read && avs_address == ADDR_TERM0
      |=> avs_readdata[FUNC_W-1:0] == $past(term_q[0].func) && avs_readdata[TERM_NC] == $past(term_q[0].nc))
    else $error("terminal read wrong");
  chk_base_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    avs_write && !avs_waitrequest && avs_address == ADDR_SPD0 |=> base_freq_q == $past(avs_writedata[FW-1:0]))
    else $error("base write lost");
  chk_bad_write: assert property (@(posedge clk) disable iff (sys_rst)
    avs_write && avs_address == ADDR_BAD |=> $stable(ctrl_q) && $stable(base_freq_q))
    else $error("unmapped write changed state");
  chk_key_fwd: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    !ctrl_q[CTRL_SRC] && ctrl_q[CTRL_KEYRUN] && !ctrl_q[CTRL_KEYREV] |=> run_cmd_q && !rev_cmd_q)
    else $error("key forward not run");
  chk_key_rev: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    !ctrl_q[CTRL_SRC] && ctrl_q[CTRL_KEYRUN] && ctrl_q[CTRL_KEYREV] |=> run_cmd_q && rev_cmd_q)
    else $error("key reverse not run");
  chk_key_no_turn: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    ctrl_q[CTRL_SRC] && ctrl_q[CTRL_KEYREV] && fwd_act && !rev_act |=> !rev_cmd_q)
    else $error("key direction changed terminal run");
  chk_stop_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    ctrl_q[CTRL_SRC] && !fwd_act && !rev_act |=> !run_cmd_q)
    else $error("run without input");
  chk_idle_decode: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    act == '0 |-> sel == 4'h0 && !fwd_act && !rev_act)
    else $error("function seen with no active terminal");
  chk_tgt_mem: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    idx_pipe_q != 4'h0 |=> target_freq_q == $past(mem_rdata))
    else $error("stored speed not used");
  chk_idx_pipe: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    1'b1 |=> idx_pipe_q == $past(speed_idx_q))
    else $error("index pipe lag");
  chk_rev_needs_run: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    rev_cmd_q |-> run_cmd_q)
    else $error("reverse without run");
  chk_sync_take: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    s2_q == s3_q |=> lvl_q == $past(s3_q))
    else $error("agreed level not taken");
  chk_sync_chain: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    1'b1 |=> s2_q == $past(s1_q) && s3_q == $past(s2_q))
    else $error("synchroniser chain broken");
endmodule

// ---- verification/ditd_switch_bank.sv ----
module ditd_switch_bank
  import ditd_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [NUM_TERM-1:0] sw_req,
  output logic      [NUM_TERM-1:0] term_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // all switches open at power-up, so no run is active when the drive starts
  initial begin
    term_pin = '0;
    forever begin
      @(posedge clk);
      term_pin <= sw_req;
    end
  end
endmodule

// ---- verification/tb.sv ----
module tb
  import ditd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk;
  logic                sys_rst;
  logic [NUM_TERM-1:0] sw_req;
  logic [NUM_TERM-1:0] term_pin;
  logic [7:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                avs_readdatavalid_q;
  logic                rv;
  logic                run_cmd_q;
  logic                rev_cmd_q;
  logic [3:0]          speed_idx_q;
  logic [FREQ_W-1:0]   target_freq_q;
  logic [31:0]         rd;
  logic [3:0]          k;
  int                  bad_count;
  int                  n_tests;

  ditd_switch_bank sw (.clk(clk), .sw_req(sw_req), .term_pin(term_pin));
  ditd_top uut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .term_pin            (term_pin),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .avs_readdatavalid_q (avs_readdatavalid_q),
    .run_cmd_q           (run_cmd_q),
    .rev_cmd_q           (rev_cmd_q),
    .speed_idx_q         (speed_idx_q),
    .target_freq_q       (target_freq_q)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    rv = avs_readdatavalid_q;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
    chk({31'h0, rv}, 32'h0000_0001, "read valid");
  endtask

  // sets the switches, lets the synchroniser settle, checks run and direction
  task automatic pins(input logic [4:0] v, input logic r, input logic rv);
    sw_req <= v;
    repeat (10) @(posedge clk);
    chk({31'h0, run_cmd_q}, {31'h0, r}, "run");
    if (r) chk({31'h0, rev_cmd_q}, {31'h0, rv}, "direction");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    sw_req = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_CTRL, CTRL_RST, "ctrl reset");
    rd_chk(ADDR_TERM0, 32'h0000_0000, "term0 reset");
    rd_chk(ADDR_TERM0 + 8'h04, 32'h0000_0001, "term1 reset");
    rd_chk(ADDR_TERM0 + 8'h08, 32'h0000_001f, "term2 reset");
    bus(1'b1, ADDR_BAD, 32'h0000_0000);
    rd_chk(ADDR_BAD, DEAD_WORD, "unmapped read");
    $display("test registers done");
    sw_req <= 5'h01;
    repeat (6) @(posedge clk);
    chk({31'h0, run_cmd_q}, 32'h0000_0000, "sync depth");
    pins(5'h01, 1'b1, 1'b0);
    pins(5'h00, 1'b0, 1'b0);
    pins(5'h02, 1'b1, 1'b1);
    pins(5'h03, 1'b0, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0000_0304, "status conflict");
    pins(5'h00, 1'b0, 1'b0);
    bus(1'b1, ADDR_TERM0, 32'h0000_0100);
    pins(5'h00, 1'b1, 1'b0);
    pins(5'h01, 1'b0, 1'b0);
    bus(1'b1, ADDR_TERM0, 32'h0000_0000);
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    pins(5'h01, 1'b1, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0000);
    pins(5'h01, 1'b0, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0006);
    pins(5'h00, 1'b1, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0000_0004);
    pins(5'h02, 1'b1, 1'b0);
    bus(1'b1, ADDR_CTRL, CTRL_RST);
    pins(5'h00, 1'b0, 1'b0);
    sw_req  <= 5'h01;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk({31'h0, run_cmd_q}, 32'h0000_0001, "run active at power-up");
    rd_chk(ADDR_CTRL, CTRL_RST, "ctrl after second reset");
    pins(5'h00, 1'b0, 1'b0);
    $display("test run decode done");
    bus(1'b1, ADDR_TERM0, {27'h0, FN_NONE});
    bus(1'b1, ADDR_TERM0 + 8'h04, {27'h0, FN_NONE});
    for (int i = 0; i < NUM_TERM; i++) begin
      bus(1'b1, ADDR_TERM0 + 8'(4 * i), {27'h0, FN_FWD});
      pins(5'(1 << i), 1'b1, 1'b0);
      bus(1'b1, ADDR_TERM0 + 8'(4 * i), {27'h0, FN_NONE});
      pins(5'h00, 1'b0, 1'b0);
    end
    $display("test terminals done");
    // select bits placed in reverse terminal order
    for (int j = 0; j < 4; j++) bus(1'b1, ADDR_TERM0 + 8'(4 * (3 - j)), {27'h0, FN_SEL0 + 5'(j)});
    for (int j = 0; j < NUM_SPEED; j++) bus(1'b1, ADDR_SPD0 + 8'(4 * j), 32'h0000_1000 + 32'(j * 273));
    rd_chk(ADDR_SPD0, 32'h0000_1000, "base freq");
    for (int j = 0; j < NUM_SPEED; j++) begin
      k = 4'(j);
      sw_req <= {1'b0, k[0], k[1], k[2], k[3]};
      repeat (12) @(posedge clk);
      chk({28'h0, speed_idx_q}, {28'h0, k}, "speed index");
      chk({16'h0, target_freq_q}, 32'h0000_1000 + 32'(j * 273), "target");
    end
    bus(1'b1, ADDR_TERM0, {27'h0, FN_NONE});
    repeat (12) @(posedge clk);
    chk({28'h0, speed_idx_q}, 32'h0000_0007, "unassigned bit");
    $display("test speed select done");
    end_sim();
  end
endmodule
